// ### hw/shcs_pkg.sv
// Purpose: Constants for the system handler control and state block
// Assumes: 32-bit register port, byte addresses, one clock
// Notes:   Reserved bits are held at zero by masks, never stored
package shcs_pkg;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          EVT_W       = 3;
    // Register byte addresses
    localparam logic [11:0] OFF_CTRL    = 12'hD24;
    localparam logic [11:0] OFF_EVT_ST  = 12'hF00;
    localparam logic [11:0] OFF_EVT_MSK = 12'hF04;
    // Field positions of the control and state register
    localparam int          B_EN_USAGE  = 18;
    localparam int          B_EN_BUS    = 17;
    localparam int          B_EN_MEM    = 16;
    localparam int          B_PD_CALL   = 15;
    localparam int          B_PD_BUS    = 14;
    localparam int          B_PD_MEM    = 13;
    localparam int          B_PD_USAGE  = 12;
    localparam int          B_AC_TIMER  = 11;
    localparam int          B_AC_SERV   = 10;
    localparam int          B_AC_DBG    = 8;
    localparam int          B_AC_CALL   = 7;
    localparam int          B_AC_USAGE  = 3;
    localparam int          B_AC_BUS    = 1;
    localparam int          B_AC_MEM    = 0;
    // Writable bits; everything else reads zero
    localparam logic [31:0] CTRL_WMASK  = 32'h0007_FD8B;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam logic [2:0]  EVT_RESET   = 3'h0;
    // Escalation event bits
    localparam int          E_MEM       = 0;
    localparam int          E_BUS       = 1;
    localparam int          E_USAGE     = 2;
    // Exception identifiers used by the core on entry and return
    typedef enum logic [2:0] {
        EXC_MEMMANAGE   = 3'h0,
        EXC_BUS_FAULT   = 3'h1,
        EXC_USAGE_FAULT = 3'h2,
        EXC_SUPER_CALL  = 3'h3,
        EXC_DEBUG_WATCH = 3'h4,
        EXC_PEND_SERV   = 3'h5,
        EXC_SYS_TIMER   = 3'h6,
        EXC_NONE        = 3'h7
    } exc_id_t;
endpackage

// ### hw/event_flags.sv
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Events and writes come from the same clock domain
// Notes:   An event in the cycle of its clear keeps the flag set
module event_flags
    import shcs_pkg::*;
#(
    parameter int W = EVT_W
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] event_in,
    input  wire logic         wr_status_in,
    input  wire logic         wr_mask_in,
    input  wire logic [W-1:0] wdata_in,
    output logic      [W-1:0] status_out,
    output logic      [W-1:0] mask_out,
    output logic              irq_out
);
    logic [W-1:0] next_status;
    logic [W-1:0] next_mask;
    logic         next_irq;

    // Write one clears; a new event wins over the clear
    always_comb begin
        next_status = status_out & ~(wr_status_in ? wdata_in : {W{1'b0}});
        next_status = next_status | event_in;
        next_mask   = wr_mask_in ? wdata_in : mask_out;
        next_irq    = |(next_status & next_mask);
    end

    // Registered so the interrupt line is glitch free
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out <= W'(EVT_RESET);
            mask_out   <= W'(EVT_RESET);
            irq_out    <= 1'b0;
        end else begin
            status_out <= next_status;
            mask_out   <= next_mask;
            irq_out    <= next_irq;
        end
    end
endmodule

// ### hw/system_handler_ctrl_state.sv
// Purpose: System handler enables, pending and active flags with register access
// Assumes: Core exception signals run on CORE_CLK_IN; only privileged code reaches the port
// Notes:   Hardware sets take priority over a software clear in the same cycle
module system_handler_ctrl_state
    import shcs_pkg::*;
(
    input  wire logic              CORE_CLK_IN,
    input  wire logic              RST_IN,
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [DATA_W-1:0] WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    input  wire logic              FAULT_MEM_IN,
    input  wire logic              FAULT_BUS_IN,
    input  wire logic              FAULT_USAGE_IN,
    input  wire logic              CALL_REQ_IN,
    input  wire logic              ENTER_IN,
    input  wire logic [2:0]        ENTER_ID_IN,
    input  wire logic              EXIT_IN,
    input  wire logic [2:0]        EXIT_ID_IN,
    output logic      [DATA_W-1:0] RDATA_OUT,
    output logic                   HARD_FAULT_OUT,
    output logic                   IRQ_OUT,
    output logic                   MEM_FAULT_EN_OUT,
    output logic                   BUS_FAULT_EN_OUT,
    output logic                   USAGE_FAULT_EN_OUT,
    output logic                   CALL_PENDING_OUT,
    output logic                   BUS_PENDING_OUT,
    output logic                   MEM_PENDING_OUT,
    output logic                   USAGE_PENDING_OUT,
    output logic                   TIMER_ACTIVE_OUT,
    output logic                   SERVICE_ACTIVE_OUT,
    output logic                   DEBUG_ACTIVE_OUT,
    output logic                   CALL_ACTIVE_OUT,
    output logic                   USAGE_ACTIVE_OUT,
    output logic                   BUS_ACTIVE_OUT,
    output logic                   MEM_ACTIVE_OUT
);
    logic [31:0]      state;
    logic [31:0]      next_state;
    logic [31:0]      next_rdata;
    logic             next_hard;
    logic             wr_ctrl;
    logic             wr_evt_st;
    logic             wr_evt_msk;
    logic [EVT_W-1:0] escalate;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;

    // Address match shared by read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // One-hot pending bit for an exception, zero where none exists
    function automatic logic [31:0] pend_bit(input logic [2:0] id);
        logic [31:0] m;
        m = ZERO_WORD;
        unique case (exc_id_t'(id))
            EXC_MEMMANAGE:   m[B_PD_MEM]   = 1'b1;
            EXC_BUS_FAULT:   m[B_PD_BUS]   = 1'b1;
            EXC_USAGE_FAULT: m[B_PD_USAGE] = 1'b1;
            EXC_SUPER_CALL:  m[B_PD_CALL]  = 1'b1;
            default:         m = ZERO_WORD;
        endcase
        return m;
    endfunction

    // One-hot active bit for an exception
    function automatic logic [31:0] act_bit(input logic [2:0] id);
        logic [31:0] m;
        m = ZERO_WORD;
        unique case (exc_id_t'(id))
            EXC_MEMMANAGE:   m[B_AC_MEM]   = 1'b1;
            EXC_BUS_FAULT:   m[B_AC_BUS]   = 1'b1;
            EXC_USAGE_FAULT: m[B_AC_USAGE] = 1'b1;
            EXC_SUPER_CALL:  m[B_AC_CALL]  = 1'b1;
            EXC_DEBUG_WATCH: m[B_AC_DBG]   = 1'b1;
            EXC_PEND_SERV:   m[B_AC_SERV]  = 1'b1;
            EXC_SYS_TIMER:   m[B_AC_TIMER] = 1'b1;
            default:         m = ZERO_WORD;
        endcase
        return m;
    endfunction

    // Write strobe decode
    assign wr_ctrl    = WR_IN && hit(ADDR_IN, OFF_CTRL);
    assign wr_evt_st  = WR_IN && hit(ADDR_IN, OFF_EVT_ST);
    assign wr_evt_msk = WR_IN && hit(ADDR_IN, OFF_EVT_MSK);

    // escalate disabled faults
    // Enables are taken from the stored value, so a write lands one cycle later
    assign escalate[E_MEM]   = FAULT_MEM_IN   && !state[B_EN_MEM];
    assign escalate[E_BUS]   = FAULT_BUS_IN   && !state[B_EN_BUS];
    assign escalate[E_USAGE] = FAULT_USAGE_IN && !state[B_EN_USAGE];

    // Next flag state: software write, then core entry and return, then hardware sets
    always_comb begin
        next_state = state;
        // software write of flags
        // The same write
        if (wr_ctrl) begin
            next_state = WDATA_IN;
        end
        if (ENTER_IN) begin
            next_state = (next_state & ~pend_bit(ENTER_ID_IN)) | act_bit(ENTER_ID_IN);
        end
        if (EXIT_IN && !(ENTER_IN && ENTER_ID_IN == EXIT_ID_IN)) begin
            next_state = next_state & ~act_bit(EXIT_ID_IN);
        end
        if (FAULT_MEM_IN && state[B_EN_MEM]) begin
            next_state[B_PD_MEM] = 1'b1;
        end
        // bus fault pends only when enabled
        if (FAULT_BUS_IN && state[B_EN_BUS]) begin
            next_state[B_PD_BUS] = 1'b1;
        end
        // usage fault pends only when enabled
        if (FAULT_USAGE_IN && state[B_EN_USAGE]) begin
            next_state[B_PD_USAGE] = 1'b1;
        end
        if (CALL_REQ_IN) begin
            next_state[B_PD_CALL] = 1'b1;
        end
        next_state = next_state & CTRL_WMASK;
        next_hard  = |escalate;
    end

    // Read mux; unmapped addresses and idle cycles return zero
    always_comb begin
        next_rdata = ZERO_WORD;
        if (RD_IN) begin
            if (hit(ADDR_IN, OFF_CTRL)) begin
                next_rdata = state & CTRL_WMASK;
            end else if (hit(ADDR_IN, OFF_EVT_ST)) begin
                next_rdata = {{(DATA_W-EVT_W){1'b0}}, evt_status};
            end else if (hit(ADDR_IN, OFF_EVT_MSK)) begin
                next_rdata = {{(DATA_W-EVT_W){1'b0}}, evt_mask};
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            state          <= CTRL_RESET;
            RDATA_OUT      <= ZERO_WORD;
            HARD_FAULT_OUT <= 1'b0;
        end else begin
            state          <= next_state;
            RDATA_OUT      <= next_rdata;
            HARD_FAULT_OUT <= next_hard;
        end
    end

    // Flag outputs are bits of the state register itself
    // memory fault enable
    assign MEM_FAULT_EN_OUT   = state[B_EN_MEM];
    assign BUS_FAULT_EN_OUT   = state[B_EN_BUS];
    assign USAGE_FAULT_EN_OUT = state[B_EN_USAGE];
    assign CALL_PENDING_OUT   = state[B_PD_CALL];
    assign BUS_PENDING_OUT    = state[B_PD_BUS];
    assign MEM_PENDING_OUT    = state[B_PD_MEM];
    assign USAGE_PENDING_OUT  = state[B_PD_USAGE];
    assign TIMER_ACTIVE_OUT   = state[B_AC_TIMER];
    assign SERVICE_ACTIVE_OUT = state[B_AC_SERV];
    assign DEBUG_ACTIVE_OUT   = state[B_AC_DBG];
    assign CALL_ACTIVE_OUT    = state[B_AC_CALL];
    assign USAGE_ACTIVE_OUT   = state[B_AC_USAGE];
    assign BUS_ACTIVE_OUT     = state[B_AC_BUS];
    assign MEM_ACTIVE_OUT     = state[B_AC_MEM];

    // Escalations are logged so software can see faults that became hard faults
    event_flags #(
        .W (EVT_W)
    ) u_evt (
        .clk_in       (CORE_CLK_IN),
        .rst_in       (RST_IN),
        .event_in     (escalate),
        .wr_status_in (wr_evt_st),
        .wr_mask_in   (wr_evt_msk),
        .wdata_in     (WDATA_IN[EVT_W-1:0]),
        .status_out   (evt_status),
        .mask_out     (evt_mask),
        .irq_out      (IRQ_OUT)
    );

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_reserved_zero;
        RD_IN && hit(ADDR_IN, OFF_CTRL) |=> (RDATA_OUT & ~CTRL_WMASK) == ZERO_WORD;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    // enabled fault pends, no hard fault
    property p_mem_gate;
        FAULT_MEM_IN && state[B_EN_MEM] && !FAULT_BUS_IN && !FAULT_USAGE_IN
            |=> MEM_PENDING_OUT && !HARD_FAULT_OUT;
    endproperty
    a_mem_gate: assert property (p_mem_gate)
        else $error("enabled memory fault not pended");

    property p_escalate;
        FAULT_USAGE_IN && !state[B_EN_USAGE]
            |=> HARD_FAULT_OUT && evt_status[E_USAGE] && (IRQ_OUT || !evt_mask[E_USAGE]);
    endproperty
    a_escalate: assert property (p_escalate)
        else $error("disabled usage fault not escalated");

    property p_call_pend;
        CALL_REQ_IN |=> CALL_PENDING_OUT;
    endproperty
    a_call_pend: assert property (p_call_pend)
        else $error("call request did not pend");

    property p_bus_pend_wr;
        wr_ctrl && !FAULT_BUS_IN && !ENTER_IN |=> BUS_PENDING_OUT == $past(WDATA_IN[B_PD_BUS]);
    endproperty
    a_bus_pend_wr: assert property (p_bus_pend_wr)
        else $error("bus pending not written");

    property p_timer_enter;
        ENTER_IN && ENTER_ID_IN == EXC_SYS_TIMER |=> TIMER_ACTIVE_OUT;
    endproperty
    a_timer_enter: assert property (p_timer_enter)
        else $error("timer entry not active");

    property p_usage_exit;
        EXIT_IN && EXIT_ID_IN == EXC_USAGE_FAULT && !ENTER_IN && !wr_ctrl |=> !USAGE_ACTIVE_OUT;
    endproperty
    a_usage_exit: assert property (p_usage_exit)
        else $error("usage active not cleared");

    property p_read_dbg;
        RD_IN && hit(ADDR_IN, OFF_CTRL) |=> RDATA_OUT[B_AC_DBG] == $past(state[B_AC_DBG]);
    endproperty
    a_read_dbg: assert property (p_read_dbg)
        else $error("debug active read wrong");

    property p_usage_pend;
        FAULT_USAGE_IN && state[B_EN_USAGE] |=> USAGE_PENDING_OUT;
    endproperty
    a_usage_pend: assert property (p_usage_pend)
        else $error("enabled usage fault not pended");

    property p_service_enter;
        ENTER_IN && ENTER_ID_IN == EXC_PEND_SERV |=> SERVICE_ACTIVE_OUT;
    endproperty
    a_service_enter: assert property (p_service_enter)
        else $error("service entry not active");

    property p_bus_exit;
        EXIT_IN && EXIT_ID_IN == EXC_BUS_FAULT && !ENTER_IN && !wr_ctrl |=> !BUS_ACTIVE_OUT;
    endproperty
    a_bus_exit: assert property (p_bus_exit)
        else $error("bus active not cleared");

    // entry trades memory pending for active
    property p_mem_enter;
        ENTER_IN && ENTER_ID_IN == EXC_MEMMANAGE && !FAULT_MEM_IN
            |=> MEM_ACTIVE_OUT && !MEM_PENDING_OUT;
    endproperty
    a_mem_enter: assert property (p_mem_enter)
        else $error("memory entry flags wrong");

    property p_call_act_wr;
        wr_ctrl && !ENTER_IN && !EXIT_IN |=> CALL_ACTIVE_OUT == $past(WDATA_IN[B_AC_CALL]);
    endproperty
    a_call_act_wr: assert property (p_call_act_wr)
        else $error("call active not written");

    property p_bus_en_wr;
        wr_ctrl |=> BUS_FAULT_EN_OUT == $past(WDATA_IN[B_EN_BUS]);
    endproperty
    a_bus_en_wr: assert property (p_bus_en_wr)
        else $error("bus enable not written");

    property p_reset_clear;
        @(posedge CORE_CLK_IN) disable iff (1'b0) RST_IN |=> state == CTRL_RESET && !IRQ_OUT;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left flags set");
endmodule

// ### test/testbench.sv
// Purpose: Self-checking bench for the system handler control and state block
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Read results are queued by the driver and checked by a monitor
module testbench
    import shcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 12'h000;
    logic [DATA_W-1:0] wdata = 32'h0000_0000;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [2:0]        flt = 3'h0;
    logic              call = 1'b0;
    logic              enter = 1'b0;
    logic              leave = 1'b0;
    logic [2:0]        eid = 3'h7;
    logic              rd_d = 1'b0;
    logic [32:0]       note;
    logic [32:0]       exp_q[$];
    int                failures = 0;
    int                n_tests = 0;
    int                pb[7] = '{13, 14, 12, 15, -1, -1, -1};
    int                ab[7] = '{0, 1, 3, 7, 8, 10, 11};
    logic [31:0]       d;
    logic [31:0]       en;
    logic [31:0]       pend;
    logic [DATA_W-1:0] RDATA_OUT;
    logic              HARD_FAULT_OUT, IRQ_OUT, MEM_FAULT_EN_OUT, BUS_FAULT_EN_OUT;
    logic              USAGE_FAULT_EN_OUT, CALL_PENDING_OUT, BUS_PENDING_OUT;
    logic              MEM_PENDING_OUT, USAGE_PENDING_OUT, TIMER_ACTIVE_OUT;
    logic              SERVICE_ACTIVE_OUT, DEBUG_ACTIVE_OUT, CALL_ACTIVE_OUT;
    logic              USAGE_ACTIVE_OUT, BUS_ACTIVE_OUT, MEM_ACTIVE_OUT;
    wire logic [31:0]  flags;

    // Flag outputs packed in register layout so they compare with read data
    assign flags = {13'h0, USAGE_FAULT_EN_OUT, BUS_FAULT_EN_OUT, MEM_FAULT_EN_OUT,
                    CALL_PENDING_OUT, BUS_PENDING_OUT, MEM_PENDING_OUT, USAGE_PENDING_OUT,
                    TIMER_ACTIVE_OUT, SERVICE_ACTIVE_OUT, 1'b0, DEBUG_ACTIVE_OUT,
                    CALL_ACTIVE_OUT, 3'h0, USAGE_ACTIVE_OUT, 1'b0, BUS_ACTIVE_OUT,
                    MEM_ACTIVE_OUT};

    system_handler_ctrl_state system_handler_ctrl_state_i (
        .CORE_CLK_IN        (clk),
        .RST_IN             (rst),
        .ADDR_IN            (addr),
        .WDATA_IN           (wdata),
        .WR_IN              (wr),
        .RD_IN              (rd),
        .FAULT_MEM_IN       (flt[0]),
        .FAULT_BUS_IN       (flt[1]),
        .FAULT_USAGE_IN     (flt[2]),
        .CALL_REQ_IN        (call),
        .ENTER_IN           (enter),
        .ENTER_ID_IN        (eid),
        .EXIT_IN            (leave),
        .EXIT_ID_IN         (eid),
        .RDATA_OUT          (RDATA_OUT),
        .HARD_FAULT_OUT     (HARD_FAULT_OUT),
        .IRQ_OUT            (IRQ_OUT),
        .MEM_FAULT_EN_OUT   (MEM_FAULT_EN_OUT),
        .BUS_FAULT_EN_OUT   (BUS_FAULT_EN_OUT),
        .USAGE_FAULT_EN_OUT (USAGE_FAULT_EN_OUT),
        .CALL_PENDING_OUT   (CALL_PENDING_OUT),
        .BUS_PENDING_OUT    (BUS_PENDING_OUT),
        .MEM_PENDING_OUT    (MEM_PENDING_OUT),
        .USAGE_PENDING_OUT  (USAGE_PENDING_OUT),
        .TIMER_ACTIVE_OUT   (TIMER_ACTIVE_OUT),
        .SERVICE_ACTIVE_OUT (SERVICE_ACTIVE_OUT),
        .DEBUG_ACTIVE_OUT   (DEBUG_ACTIVE_OUT),
        .CALL_ACTIVE_OUT    (CALL_ACTIVE_OUT),
        .USAGE_ACTIVE_OUT   (USAGE_ACTIVE_OUT),
        .BUS_ACTIVE_OUT     (BUS_ACTIVE_OUT),
        .MEM_ACTIVE_OUT     (MEM_ACTIVE_OUT)
    );

    // 40 MHz core clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Comparison with case equality so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One bus cycle; strobes stay as set until the next call, so cycles chain
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] v);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= v;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        bus(1'b1, 1'b0, a, v);
    endtask

    // Expected word is noted before the strobe; c marks a control register read
    task automatic rd_reg(input logic [11:0] a, input logic [31:0] e, input logic c);
        exp_q.push_back({c, e});
        bus(1'b0, 1'b1, a, 32'h0000_0000);
    endtask

    // One-cycle core exception pulse with the bus idle
    task automatic core(input logic [2:0] f, input logic c, input logic en_i,
                        input logic [2:0] id, input logic ex);
        wr <= 1'b0;
        rd <= 1'b0;
        flt <= f;
        call <= c;
        enter <= en_i;
        leave <= ex;
        eid <= id;
        @(posedge clk);
        flt <= 3'h0;
        call <= 1'b0;
        enter <= 1'b0;
        leave <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe; flags must agree on control register reads
    always @(posedge clk) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            check(RDATA_OUT, note[31:0]);
            if (note[32]) check(flags, note[31:0]);
        end
        rd_d <= rd;
    end

    // Watchdog sized well beyond the whole sequence
    initial begin
        #(25 * 20000);
        failures++;
        close_out();
    end

    initial begin
        void'($urandom(72));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(OFF_CTRL, 32'h0000_0000, 1'b1);
        rd_reg(OFF_EVT_ST, 32'h0000_0000, 1'b0);
        rd_reg(OFF_EVT_MSK, 32'h0000_0000, 1'b0);
        // walking bit readback, back to back, reserved bits stay zero
        for (int b = 0; b < 32; b++) begin
            wr_reg(OFF_CTRL, 32'h0000_0001 << b);
            rd_reg(OFF_CTRL, (32'h0000_0001 << b) & CTRL_WMASK, 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            wr_reg(OFF_CTRL, d);
            wr_reg(12'h100, ~d);
            rd_reg(OFF_CTRL, d & CTRL_WMASK, 1'b1);
            rd_reg(12'h100, 32'h0000_0000, 1'b0);
        end
        $display("register access test done");
        // escalation of disabled faults with mask 101
        wr_reg(OFF_EVT_MSK, 32'h0000_0005);
        wr_reg(OFF_CTRL, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            core(3'(1 << k), 1'b0, 1'b0, 3'h7, 1'b0);
            #1;
            check(32'(HARD_FAULT_OUT), 32'h0000_0001);
            check(32'(IRQ_OUT), 32'(k != 1));
            rd_reg(OFF_EVT_ST, 32'(1 << k), 1'b0);
            #1;
            check(32'(HARD_FAULT_OUT), 32'h0000_0000);
            wr_reg(OFF_EVT_ST, 32'(1 << k));
            bus(1'b0, 1'b0, 12'h000, 32'h0000_0000);
            #1;
            check(32'(IRQ_OUT), 32'h0000_0000);
        end
        $display("escalation test done");
        // Enabled faults and calls go pending, then active on entry, cleared on return
        en = 32'h0007_0000;
        for (int id = 0; id < 7; id++) begin
            wr_reg(OFF_CTRL, en);
            pend = (pb[id] >= 0) ? (32'h0000_0001 << pb[id]) : 32'h0000_0000;
            if (id < 4) begin
                core((id < 3) ? 3'(1 << id) : 3'h0, id == 3, 1'b0, 3'h7, 1'b0);
                #1;
                check(32'(HARD_FAULT_OUT), 32'h0000_0000);
            end
            rd_reg(OFF_CTRL, en | pend, 1'b1);
            core(3'h0, 1'b0, 1'b1, 3'(id), 1'b0);
            rd_reg(OFF_CTRL, en | (32'h0000_0001 << ab[id]), 1'b1);
            core(3'h0, 1'b0, 1'b0, 3'(id), 1'b1);
            rd_reg(OFF_CTRL, en, 1'b1);
        end
        // Entry and return of one exception in one cycle leave it active
        core(3'h0, 1'b0, 1'b1, EXC_DEBUG_WATCH, 1'b1);
        rd_reg(OFF_CTRL, en | (32'h0000_0001 << B_AC_DBG), 1'b1);
        // Hardware set beats a software clear in the same cycle
        call <= 1'b1;
        wr_reg(OFF_CTRL, 32'h0000_0000);
        call <= 1'b0;
        rd_reg(OFF_CTRL, 32'h0000_8000, 1'b1);
        $display("exception state test done");
        wr_reg(OFF_CTRL, 32'hFFFF_FFFF);
        core(3'h2, 1'b0, 1'b0, 3'h7, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(OFF_CTRL, 32'h0000_0000, 1'b1);
        rd_reg(OFF_EVT_ST, 32'h0000_0000, 1'b0);
        rd_reg(OFF_EVT_MSK, 32'h0000_0000, 1'b0);
        bus(1'b0, 1'b0, 12'h000, 32'h0000_0000);
        #1;
        check(32'(IRQ_OUT), 32'h0000_0000);
        $display("reset test done");
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule
